// ### src/lucl_pkg.sv
// Shared constants and types for the line unit clock and signal-loss control block.
package lucl_pkg;

  // Register port geometry.
  localparam int ADDR_W = 8;   // Byte address width of the register port.
  localparam int DATA_W = 32;  // Data width of the register port.

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS  = 8'h00;  // Control, read and write.
  localparam logic [7:0] STAT_OFS  = 8'h04;  // Live status, read only.
  localparam logic [7:0] ISTAT_OFS = 8'h08;  // Sticky event status, read only.
  localparam logic [7:0] IEN_OFS   = 8'h0C;  // Event enable, read and write.
  localparam logic [7:0] ICLR_OFS  = 8'h10;  // Event clear, write one to clear.

  // Control register layout, bit 0 is the last field.
  typedef struct packed {
    logic rclk_falling;               // Launch receive data on the falling edge.
    logic tx_hiz;                     // Force the line drivers to high impedance.
    logic hw_mode;                    // Hardware control mode.
    logic ref_mclk;                   // Master clock selected as transmit pattern reference.
    logic alarm_indication_signal;    // Send the alarm indication signal.
    logic automatic_all_ones_send;    // Automatic all ones send active.
    logic loopback_code_send;         // Send in-band loopback codes.
    logic prbs_send;                  // Send PRBS or QRSS pattern.
    logic all_zeros_send;             // Send all zeros.
    logic all_ones_send;              // Send all ones.
    logic dual_rail;                  // Dual rail receive interface.
    logic cdr_bypass;                 // Clock recovery bypassed.
    logic alarm_substitution_enable;  // Clock from master clock during signal loss.
  } lucl_ctrl_t;
  localparam int         CTRL_W   = 13;       // Width of the control register.
  localparam lucl_ctrl_t CTRL_RST = 13'h0000;  // Control value after reset.

  // Event bits, shared by sticky status, enable and clear registers.
  typedef struct packed {
    logic mclk_lost;     // Master clock has stopped.
    logic los_clear;     // Received signal came back.
    logic los_set;       // Received signal was lost.
    logic txclk_missing; // Transmit clock declared missing.
  } lucl_evt_t;
  localparam int        EVT_W   = 4;     // Width of the event registers.
  localparam lucl_evt_t EVT_RST = 4'h0;  // Event register value after reset.

  // Source of the receive clock output.
  typedef enum logic [1:0] {
    SRC_RECOVERED,
    SRC_MCLK,
    SRC_RAILS_XOR
  } lucl_rclk_src_t;

  // Bit positions of the synchronised input vector.
  localparam int SYN_MCLK = 0;  // Master reference clock.
  localparam int SYN_TXCK = 1;  // Transmit clock input.
  localparam int SYN_REC  = 2;  // Recovered clock.
  localparam int SYN_SLP  = 3;  // Positive rail slicer output.
  localparam int SYN_SLN  = 4;  // Negative rail slicer output.
  localparam int SYN_LOS  = 5;  // Signal-loss detector level.
  localparam int SYN_RXP  = 6;  // Decoded positive rail data.
  localparam int SYN_RXN  = 7;  // Decoded negative rail data.
  localparam int SYN_W    = 8;  // Width of the synchronised vector.

  // Timing.
  localparam int CLK_SYS_PERIOD_NS  = 8;     // System clock period.
  localparam int TXCLK_MISS_MCLK    = 70;    // Master clock cycles without a transmit edge.
  localparam int MCLK_LOSS_NS       = 2000;  // Least time without master clock edges.
  localparam int MCLK_LOSS_CYC      =
    (MCLK_LOSS_NS + CLK_SYS_PERIOD_NS - 1) / CLK_SYS_PERIOD_NS;  // Rounded up.

endpackage

// ### src/lucl_clock_los.sv
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
// Function
// - Transmit clock missing after 70 steady master cycles
// - Missing transmit clock raises enabled interrupt
// - Receive clock at T1/J1 or E1 rate
// - Signal loss with substitution: receive clock from master
// - Recovery active: receive clock is recovered clock
// - Receive data launched on active receive edge
// - Bypass: receive clock is rail XOR
// - Master clock times recovery, attenuator, control port; the register port runs on clk_sys_i
// - Master reference times patterns and loopback codes
// - Automatic all ones and alarm always master
// - Hardware mode all ones and PRBS use master clock
// - Lost master clock tristates both line drivers
// - Loss output high while signal lost
// - Loss output returns low by itself
module lucl_clock_los (
  input  wire logic                        clk_sys_i,              // System clock.
  input  wire logic                        reset_n_i,              // Asynchronous reset.
  input  wire logic                        master_clock_i,         // Master reference clock.
  input  wire logic                        transmit_clock_in_i,    // Transmit clock pin.
  input  wire logic                        recovered_clock_i,      // Clock from recovery.
  input  wire logic                        slicer_positive_i,      // Positive slicer rail.
  input  wire logic                        slicer_negative_i,      // Negative slicer rail.
  input  wire logic                        los_detect_i,           // Signal-loss detector.
  input  wire logic                        rx_decoded_positive_i,  // Decoded positive data.
  input  wire logic                        rx_decoded_negative_i,  // Decoded negative data.
  input  wire logic                        tx_encoded_positive_i,  // Encoder positive pulse.
  input  wire logic                        tx_encoded_negative_i,  // Encoder negative pulse.
  input  wire logic [lucl_pkg::ADDR_W-1:0] reg_addr_i,             // Register address.
  input  wire logic [lucl_pkg::DATA_W-1:0] reg_wdata_i,            // Register write data.
  input  wire logic                        reg_write_i,            // Write strobe.
  input  wire logic                        reg_read_i,             // Read strobe.
  output logic      [lucl_pkg::DATA_W-1:0] reg_rdata_o,            // Read data, next cycle.
  output logic                             rclk_o,                 // Receive clock output.
  output logic                             rx_positive_rail_o,     // Receive data or rail.
  output logic                             rx_negative_rail_o,     // Negative receive rail.
  output logic                             los_o,                  // Loss of signal.
  output logic                             tx_line_positive_o,     // Positive driver data.
  output logic                             tx_line_positive_oe_o,  // Positive driver enable.
  output logic                             tx_line_negative_o,     // Negative driver data.
  output logic                             tx_line_negative_oe_o,  // Negative driver enable.
  output logic                             tx_ref_mclk_o,          // Transmit timed by master.
  output logic                             tx_bit_strobe_o,        // Transmit bit timing pulse.
  output logic                             mclk_tick_o,            // Master clock timing pulse.
  output logic                             irq_o                   // Interrupt, active high.
);

  // Widths of the two watchdog counters.
  localparam int TXC_W = $clog2(lucl_pkg::TXCLK_MISS_MCLK + 2);
  localparam int MLC_W = $clog2(lucl_pkg::MCLK_LOSS_CYC + 1);
  localparam logic [TXC_W-1:0] TXC_LIMIT = TXC_W'(lucl_pkg::TXCLK_MISS_MCLK);
  localparam logic [MLC_W-1:0] MLC_LIMIT = MLC_W'(lucl_pkg::MCLK_LOSS_CYC);

  // Detects a level change between two samples.
  function automatic logic changed(input logic cur, input logic prev);
    changed = cur ^ prev;
  endfunction

  // Detects a rising transition between two samples.
  function automatic logic rose(input logic cur, input logic prev);
    rose = cur & ~prev;
  endfunction

  logic [lucl_pkg::SYN_W-1:0]  sync1_reg;        // First synchroniser stage.
  logic [lucl_pkg::SYN_W-1:0]  sync2_reg;        // Second synchroniser stage.
  logic                        mclk_prev_reg;    // Previous master clock sample.
  logic                        txck_prev_reg;    // Previous transmit clock sample.
  logic [TXC_W-1:0]            txc_cnt_reg;      // Master rising edges since transmit edge.
  logic [MLC_W-1:0]            mlc_cnt_reg;      // System cycles since master edge.
  lucl_pkg::lucl_ctrl_t        ctrl_reg;         // Control register.
  lucl_pkg::lucl_evt_t         ists_reg;         // Sticky event status.
  lucl_pkg::lucl_evt_t         ien_reg;          // Event enable.
  logic                        miss_prev_reg;    // Previous missing level.
  logic                        lost_prev_reg;    // Previous master lost level.
  logic                        los_reg;          // Loss of signal output flop.
  logic                        rclk_reg;         // Receive clock output flop.
  logic                        rxp_reg;          // Positive receive data flop.
  logic                        rxn_reg;          // Negative receive data flop.
  logic                        txp_reg;          // Positive driver data flop.
  logic                        txn_reg;          // Negative driver data flop.
  logic                        tx_oe_reg;        // Driver enable flop.
  logic                        txref_reg;        // Transmit reference flop.
  logic                        txstb_reg;        // Transmit strobe flop.
  logic                        mtick_reg;        // Master tick flop.
  logic [lucl_pkg::DATA_W-1:0] rdata_reg;        // Read data flop.

  // Named views of the synchronised inputs.
  wire mclk_s  = sync2_reg[lucl_pkg::SYN_MCLK];
  wire txck_s  = sync2_reg[lucl_pkg::SYN_TXCK];
  wire rec_s   = sync2_reg[lucl_pkg::SYN_REC];
  wire slp_s   = sync2_reg[lucl_pkg::SYN_SLP];
  wire sln_s   = sync2_reg[lucl_pkg::SYN_SLN];
  wire los_s   = sync2_reg[lucl_pkg::SYN_LOS];
  wire rxp_s   = sync2_reg[lucl_pkg::SYN_RXP];
  wire rxn_s   = sync2_reg[lucl_pkg::SYN_RXN];

  // Edge and condition decode.
  wire mclk_rise   = rose(mclk_s, mclk_prev_reg);
  wire mclk_edge   = changed(mclk_s, mclk_prev_reg);
  wire txck_rise   = rose(txck_s, txck_prev_reg);
  wire txck_edge   = changed(txck_s, txck_prev_reg);
  wire txc_missing = txc_cnt_reg > TXC_LIMIT;
  wire mclk_lost   = mlc_cnt_reg >= MLC_LIMIT;
  wire sub_active  = los_s & ctrl_reg.alarm_substitution_enable;

  // Receive clock source: substitution first, then bypass, else recovered.
  lucl_pkg::lucl_rclk_src_t rclk_src;
  assign rclk_src = sub_active        ? lucl_pkg::SRC_MCLK :
                    ctrl_reg.cdr_bypass ? lucl_pkg::SRC_RAILS_XOR :
                                          lucl_pkg::SRC_RECOVERED;

  // Receive clock next value; the master clock already runs at the line rate.
  logic rclk_next;
  always_comb begin
    case (rclk_src)
      lucl_pkg::SRC_MCLK:      rclk_next = mclk_s;
      lucl_pkg::SRC_RAILS_XOR: rclk_next = slp_s ^ sln_s;
      lucl_pkg::SRC_RECOVERED: rclk_next = rec_s;
      default:                 rclk_next = rec_s;
    endcase
  end

  // Active edge of the receive clock as it is about to appear on the output.
  wire rx_launch = changed(rclk_next, rclk_reg) &
                   (rclk_next == ~ctrl_reg.rclk_falling);

  // Transmit patterns that may be timed from the master clock.
  wire pat_any  = ctrl_reg.all_ones_send | ctrl_reg.all_zeros_send |
                  ctrl_reg.prbs_send | ctrl_reg.loopback_code_send;
  wire ref_next = ctrl_reg.automatic_all_ones_send |
                  ctrl_reg.alarm_indication_signal |
                  (ctrl_reg.ref_mclk & pat_any) |
                  (ctrl_reg.hw_mode & (ctrl_reg.all_ones_send | ctrl_reg.prbs_send));

  // Events that set sticky status bits.
  lucl_pkg::lucl_evt_t evt;
  assign evt.txclk_missing = txc_missing & ~miss_prev_reg;
  assign evt.los_set       = rose(los_s, los_reg);
  assign evt.los_clear     = rose(los_reg, los_s);
  assign evt.mclk_lost     = mclk_lost & ~lost_prev_reg;

  // Register port decode.
  wire wr_ctrl = reg_write_i & (reg_addr_i == lucl_pkg::CTRL_OFS);
  wire wr_ien  = reg_write_i & (reg_addr_i == lucl_pkg::IEN_OFS);
  wire wr_iclr = reg_write_i & (reg_addr_i == lucl_pkg::ICLR_OFS);
  lucl_pkg::lucl_evt_t clr_mask;
  assign clr_mask = wr_iclr ? lucl_pkg::lucl_evt_t'(reg_wdata_i[lucl_pkg::EVT_W-1:0])
                            : lucl_pkg::EVT_RST;

  // Live status word: source, master lost, transmit missing, loss.
  wire [4:0] stat_word = {rclk_src, mclk_lost, txc_missing, los_reg};

  // Read multiplexer; unmapped addresses read zero.
  logic [lucl_pkg::DATA_W-1:0] rdata_next;
  always_comb begin
    rdata_next = '0;
    case (reg_addr_i)
      lucl_pkg::CTRL_OFS:  rdata_next = {{(lucl_pkg::DATA_W - lucl_pkg::CTRL_W){1'h0}}, ctrl_reg};
      lucl_pkg::STAT_OFS:  rdata_next = {{(lucl_pkg::DATA_W - 5){1'h0}}, stat_word};
      lucl_pkg::ISTAT_OFS: rdata_next = {{(lucl_pkg::DATA_W - lucl_pkg::EVT_W){1'h0}}, ists_reg};
      lucl_pkg::IEN_OFS:   rdata_next = {{(lucl_pkg::DATA_W - lucl_pkg::EVT_W){1'h0}}, ien_reg};
      default:             rdata_next = '0;
    endcase
  end

  // Two-stage synchronisers for the eight receive and clock inputs, plus edge history.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_reg     <= '0;
      sync2_reg     <= '0;
      mclk_prev_reg <= 1'h0;
      txck_prev_reg <= 1'h0;
    end else begin
      sync1_reg     <= {rx_decoded_negative_i, rx_decoded_positive_i, los_detect_i,
                        slicer_negative_i, slicer_positive_i, recovered_clock_i,
                        transmit_clock_in_i, master_clock_i};
      sync2_reg     <= sync1_reg;
      mclk_prev_reg <= mclk_s;
      txck_prev_reg <= txck_s;
    end
  end

  // Counts master rising edges while the transmit clock holds still; saturates.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      txc_cnt_reg <= '0;
    end else if (txck_edge) begin
      txc_cnt_reg <= '0;
    end else if (mclk_rise && !txc_missing) begin
      txc_cnt_reg <= txc_cnt_reg + TXC_W'(1);
    end
  end

  // Counts system cycles since the last master clock transition.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mlc_cnt_reg <= '0;
    end else if (mclk_edge) begin
      mlc_cnt_reg <= '0;
    end else if (!mclk_lost) begin
      mlc_cnt_reg <= mlc_cnt_reg + MLC_W'(1);
    end
  end

  // Control and enable registers, written by software.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_reg <= lucl_pkg::CTRL_RST;
      ien_reg  <= lucl_pkg::EVT_RST;
    end else begin
      if (wr_ctrl) ctrl_reg <= lucl_pkg::lucl_ctrl_t'(reg_wdata_i[lucl_pkg::CTRL_W-1:0]);
      if (wr_ien)  ien_reg  <= lucl_pkg::lucl_evt_t'(reg_wdata_i[lucl_pkg::EVT_W-1:0]);
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ists_reg      <= lucl_pkg::EVT_RST;
      miss_prev_reg <= 1'h0;
      lost_prev_reg <= 1'h0;
    end else begin
      ists_reg      <= (ists_reg & ~clr_mask) | evt;
      miss_prev_reg <= txc_missing;
      lost_prev_reg <= mclk_lost;
    end
  end

  // Receive side outputs: loss flag, receive clock and launched data.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      los_reg  <= 1'h0;
      rclk_reg <= 1'h0;
      rxp_reg  <= 1'h0;
      rxn_reg  <= 1'h0;
    end else begin
      los_reg  <= los_s;
      rclk_reg <= rclk_next;
      if (rx_launch) begin
        rxp_reg <= rxp_s;
        rxn_reg <= ctrl_reg.dual_rail & rxn_s;
      end
    end
  end

  // Transmit side: driver data and enables, reference choice and timing pulses.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      txp_reg   <= 1'h0;
      txn_reg   <= 1'h0;
      tx_oe_reg <= 1'h0;
      txref_reg <= 1'h0;
      txstb_reg <= 1'h0;
      mtick_reg <= 1'h0;
    end else begin
      txp_reg   <= tx_encoded_positive_i;
      txn_reg   <= tx_encoded_negative_i;
      tx_oe_reg <= ~mclk_lost & ~ctrl_reg.tx_hiz;
      txref_reg <= ref_next;
      txstb_reg <= ref_next ? mclk_rise : txck_rise;
      mtick_reg <= mclk_rise;
    end
  end

  // Register read data, valid the cycle after the read strobe.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_reg <= '0;
    end else if (reg_read_i) begin
      rdata_reg <= rdata_next;
    end
  end

  // Output assignments.
  assign reg_rdata_o           = rdata_reg;
  assign rclk_o                = rclk_reg;
  assign rx_positive_rail_o    = rxp_reg;
  assign rx_negative_rail_o    = rxn_reg;
  assign los_o                 = los_reg;
  assign tx_line_positive_o    = txp_reg;
  assign tx_line_negative_o    = txn_reg;
  assign tx_line_positive_oe_o = tx_oe_reg;
  assign tx_line_negative_oe_o = tx_oe_reg;
  assign tx_ref_mclk_o         = txref_reg;
  assign tx_bit_strobe_o       = txstb_reg;
  assign mclk_tick_o           = mtick_reg;
  assign irq_o                 = |(ists_reg & ien_reg);

  // Checks, all on the system clock.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  // A loss that starts on the line.
  sequence loss_begins;
    $rose(los_s);
  endsequence

  // A loss that ends on the line.
  sequence loss_ends;
    $fell(los_s);
  endsequence

  AST_MISS_AT_LIMIT: assert property ($rose(txc_missing) |->
    $past(txc_cnt_reg) == TXC_LIMIT && $past(mclk_rise) && !$past(txck_edge))
    else $error("Transmit clock missing declared at the wrong count.");

  AST_MISS_IRQ: assert property (evt.txclk_missing && ien_reg.txclk_missing
    |=> irq_o && ists_reg.txclk_missing)
    else $error("Missing transmit clock did not raise the interrupt.");

  AST_RCLK_SUB: assert property (sub_active |=> rclk_o == $past(mclk_s))
    else $error("Receive clock not taken from master clock during loss.");

  AST_RCLK_REC: assert property (!sub_active && !ctrl_reg.cdr_bypass
    |=> rclk_o == $past(rec_s))
    else $error("Receive clock does not follow the recovered clock.");

  AST_RCLK_XOR: assert property (!sub_active && ctrl_reg.cdr_bypass
    |=> rclk_o == ($past(slp_s) ^ $past(sln_s)))
    else $error("Receive clock is not the rail XOR in bypass.");

  AST_RX_LAUNCH: assert property (rx_launch |=> rx_positive_rail_o == $past(rxp_s)
    && rclk_o == ~ctrl_reg.rclk_falling)
    else $error("Receive data not launched on the active edge.");

  AST_DRIVER_HIZ: assert property (mclk_lost |=>
    !tx_line_positive_oe_o && !tx_line_negative_oe_o)
    else $error("Line drivers enabled with master clock lost.");

  AST_LOS_SET: assert property (loss_begins |=> los_o ##1 ists_reg.los_set)
    else $error("Loss output did not rise with the lost signal.");

  AST_LOS_CLEAR: assert property (loss_ends ##1 !los_s |-> !los_o ##1 ists_reg.los_clear)
    else $error("Loss output did not return low by itself.");

  AST_ALARM_REF: assert property (ctrl_reg.alarm_indication_signal
    |=> tx_ref_mclk_o)
    else $error("Alarm signal not timed from the master clock.");

  AST_MTICK: assert property (mclk_rise |=> mclk_tick_o ##1 !mclk_tick_o)
    else $error("Master timing pulse missing or too long.");

  AST_MISS_RESTART: assert property (txck_edge |=> !txc_missing)
    else $error("Transmit clock edge did not restart the missing count.");

endmodule // lucl_clock_los

// ### bench/lucl_line_model.sv
`timescale 1ns/1ns
// Stand-in for the line and framer side: master clock, transmit clock and receive pins.
module lucl_line_model (
  input  wire logic mclk_run_i,             // Master oscillator enable.
  input  wire logic txck_run_i,             // Framer transmit clock enable.
  input  wire logic los_i,                  // Received signal lost when high.
  input  wire logic rail_p_i,               // Positive slicer rail level.
  input  wire logic rail_n_i,               // Negative slicer rail level.
  output logic      master_clock_o,         // Master reference clock.
  output logic      transmit_clock_o,       // Transmit clock from the framer.
  output logic      recovered_clock_o,      // Clock from the recovery unit.
  output logic      slicer_positive_o,      // Positive slicer output.
  output logic      slicer_negative_o,      // Negative slicer output.
  output logic      los_detect_o            // Signal-loss detector level.
);
  logic mclk_q = 1'h0;  // Master clock state.
  logic txck_q = 1'h0;  // Transmit clock state.
  logic rec_q  = 1'h0;  // Recovered clock state.
  // E1 master reference at 2.048 MHz, parked low once stopped.
  // It starts 2 ns late so that its edges never meet a system clock edge.
  initial begin
    #2;
    forever #244 mclk_q = mclk_run_i ? ~mclk_q : 1'h0;
  end
  // Transmit clock of 64 ns period, frozen at its level while stopped.
  always #32 txck_q = txck_run_i ? ~txck_q : txck_q;
  // Recovered clock runs free near the T1 rate, also kept off the system edges.
  initial begin
    #2;
    forever #324 rec_q = ~rec_q;
  end
  assign master_clock_o    = mclk_q;
  assign transmit_clock_o  = txck_q;
  assign recovered_clock_o = rec_q;
  assign slicer_positive_o = rail_p_i;
  assign slicer_negative_o = rail_n_i;
  assign los_detect_o      = los_i;
endmodule // lucl_line_model

// ### bench/lucl_clock_los_bench.sv
`timescale 1ns/1ns
// Self-checking bench for the clock and signal-loss control block.
module lucl_clock_los_bench;
  logic        clk_sys_i = 1'h0;    // System clock, 8 ns.
  logic        reset_n_i = 1'h0;    // Active low reset.
  logic        mclk_run  = 1'h1;    // Master clock running.
  logic        txck_run  = 1'h1;    // Transmit clock running.
  logic        los_in    = 1'h0;    // Line loss level.
  logic        rail_p    = 1'h0;    // Positive slicer rail.
  logic        rail_n    = 1'h0;    // Negative slicer rail.
  logic [7:0]  reg_addr_i  = 8'h00; // Register address.
  logic [31:0] reg_wdata_i = 32'h0; // Register write data.
  logic        reg_write_i = 1'h0;  // Write strobe.
  logic        reg_read_i  = 1'h0;  // Read strobe.
  logic        rx_positive_rail_o, rx_negative_rail_o, tx_ref_mclk_o;  // Receive data, reference.
  logic        master_clock_i, transmit_clock_in_i, recovered_clock_i;
  logic        slicer_positive_i, slicer_negative_i, los_detect_i;
  logic [31:0] reg_rdata_o;         // Read data.
  logic        rclk_o, los_o, irq_o, tx_line_positive_oe_o, tx_line_negative_oe_o;
  int          err_total    = 0;    // Mismatches.
  int          total_checks = 0;    // Comparisons.
  int          cycles       = 0;    // Cycles run.

  lucl_line_model lucl_line_model_i (.mclk_run_i(mclk_run), .txck_run_i(txck_run),
    .los_i(los_in), .rail_p_i(rail_p), .rail_n_i(rail_n), .master_clock_o(master_clock_i),
    .transmit_clock_o(transmit_clock_in_i), .recovered_clock_o(recovered_clock_i),
    .slicer_positive_o(slicer_positive_i), .slicer_negative_o(slicer_negative_i),
    .los_detect_o(los_detect_i));

  lucl_clock_los lucl_clock_los_i (.clk_sys_i, .reset_n_i, .master_clock_i,
    .transmit_clock_in_i, .recovered_clock_i, .slicer_positive_i, .slicer_negative_i,
    .los_detect_i, .rx_decoded_positive_i(slicer_positive_i),
    .rx_decoded_negative_i(slicer_negative_i), .tx_encoded_positive_i(1'h1),
    .tx_encoded_negative_i(1'h0), .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i,
    .reg_rdata_o, .rclk_o, .rx_positive_rail_o, .rx_negative_rail_o, .los_o,
    .tx_line_positive_o(), .tx_line_positive_oe_o, .tx_line_negative_o(),
    .tx_line_negative_oe_o, .tx_ref_mclk_o, .tx_bit_strobe_o(), .mclk_tick_o(), .irq_o);

  // System clock generator.
  always #4 clk_sys_i = ~clk_sys_i;

  // Prints the verdict and ends the run.
  task automatic give_verdict;
    if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Compares a value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One-cycle register write.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'h1;
    @(posedge clk_sys_i);
    reg_write_i <= 1'h0;
  endtask

  // One-cycle register read; the data are checked in the following cycle.
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_read_i <= 1'h1;
    @(posedge clk_sys_i);
    reg_read_i <= 1'h0;
    #1 chk(reg_rdata_o, exp, what);
  endtask

  // Writes the control word and checks which clock times the transmit side.
  task automatic ref_case(input logic [31:0] ctl, input logic exp, input string what);
    wr_reg(8'h00, ctl);
    repeat (2) @(posedge clk_sys_i);
    chk(32'(tx_ref_mclk_o), 32'(exp), what);
  endtask

  // Cuts a hung run short.
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  // Main sequence.
  initial begin
    repeat (12) @(posedge clk_sys_i);
    reset_n_i <= 1'h1;
    repeat (12) @(posedge clk_sys_i);
    rd_reg(8'h00, 32'h0, "control reset");
    rd_reg(8'h40, 32'h0, "unmapped read");
    chk(32'(tx_line_positive_oe_o), 32'h1, "driver on");
    wr_reg(8'h00, 32'h1);
    @(posedge clk_sys_i) los_in <= 1'h1;
    repeat (8) @(posedge clk_sys_i);
    chk(32'(los_o), 32'h1, "loss high");
    rd_reg(8'h04, 32'h9, "source master");
    @(posedge clk_sys_i) los_in <= 1'h0;
    repeat (8) @(posedge clk_sys_i);
    chk(32'(los_o), 32'h0, "loss low");
    rd_reg(8'h04, 32'h0, "source recovered");
    rd_reg(8'h08, 32'h6, "loss events");
    chk(32'(irq_o), 32'h0, "irq masked");
    wr_reg(8'h10, 32'h6);
    rd_reg(8'h08, 32'h0, "events cleared");
    wr_reg(8'h00, 32'h2);
    @(posedge clk_sys_i) rail_p <= 1'h1;
    repeat (8) @(posedge clk_sys_i);
    chk(32'(rclk_o), 32'h1, "rails one");
    @(posedge clk_sys_i) rail_n <= 1'h1;
    repeat (8) @(posedge clk_sys_i);
    chk(32'(rclk_o), 32'h0, "rails equal");
    rd_reg(8'h04, 32'h10, "source xor");
    wr_reg(8'h0C, 32'h1);
    @(posedge clk_sys_i) txck_run <= 1'h0;
    #(60 * 488);
    rd_reg(8'h04, 32'h10, "not yet missing");
    #(13 * 488);
    rd_reg(8'h04, 32'h12, "transmit clock missing");
    chk(32'(irq_o), 32'h1, "irq raised");
    @(posedge clk_sys_i) txck_run <= 1'h1;
    repeat (20) @(posedge clk_sys_i);
    rd_reg(8'h04, 32'h10, "missing cleared");
    wr_reg(8'h10, 32'h1);
    #1 chk(32'(irq_o), 32'h0, "irq cleared");
    wr_reg(8'h00, 32'h4);
    repeat (200) @(posedge clk_sys_i);
    chk(32'({rx_positive_rail_o, rx_negative_rail_o}), 32'h3, "dual rail data");
    ref_case(32'h200, 1'h0, "master without pattern");
    ref_case(32'h208, 1'h1, "master all ones");
    ref_case(32'h100, 1'h1, "alarm on master");
    ref_case(32'h080, 1'h1, "auto ones on master");
    ref_case(32'h420, 1'h1, "hardware prbs on master");
    ref_case(32'h000, 1'h0, "transmit clock reference");
    @(posedge clk_sys_i) mclk_run <= 1'h0;
    repeat (300) @(posedge clk_sys_i);
    chk(32'({tx_line_positive_oe_o, tx_line_negative_oe_o}), 32'h0, "drivers off");
    rd_reg(8'h04, 32'h4, "master lost status");
    rd_reg(8'h08, 32'h8, "master clock lost");
    give_verdict();
  end
endmodule // lucl_clock_los_bench
